/* common/tx_framing_defines.vh */
// Functional notes
// RULE1: link marks first word of each unit
// RULE2: packet modes: space high if selected, above threshold
// RULE3: space low when port full or unselected
// RULE4: level-3 cell mode: space output held low
// RULE5: level-2 packet: drive only while selected, enabled
// RULE6: drive in level-3 modes; tristate level-2 cell
// RULE7: space output high impedance during global reset
// RULE8: last-word marker honoured in packet modes only
// RULE9: link strobes in-band address before data
// RULE10: later transfers go to captured in-band port
// RULE11: strobe valid only with enable high, level-3 packet
// RULE12: modulus 00..11 gives 4..1 valid bytes
// RULE13: modulus read only with last-word marker
// RULE14: 16-bit ignores upper bit; 8-bit, cells ignore both
// RULE15: active-low enable moves one word per edge; outside level-3 packet mode the first enable-low edge of a burst moves none
// RULE16: error with last marker aborts packet, packet modes
// RULE17: in-band address word never enters the fifo
// RULE18: one port per burst; space updated each edge
`ifndef TX_FRAMING_DEFINES_VH
`define TX_FRAMING_DEFINES_VH

// register byte offsets
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_ABORT_COUNT   4'h8
`define REG_DROP_COUNT    4'hc

// control register fields
`define CTRL_MODE_LSB     0
`define CTRL_MODE_MSB     1
`define CTRL_WIDTH_LSB    2
`define CTRL_WIDTH_MSB    3
`define CTRL_DP_RESET_BIT 4
`define CTRL_RESET_MODE   2'h0
`define CTRL_RESET_WIDTH  2'h0

// status register fields
`define STAT_PORT_LSB     0
`define STAT_PORT_MSB     7
`define STAT_SELECTED_BIT 8
`define STAT_IN_PKT_BIT   9
`define STAT_LEVEL_LSB    10

// bus modes
`define MODE_L2_CELL      2'h0
`define MODE_L3_CELL      2'h1
`define MODE_L2_PKT       2'h2
`define MODE_L3_PKT       2'h3

// bus widths
`define WIDTH_8           2'h0
`define WIDTH_16          2'h1
`define WIDTH_32          2'h2

// fifo geometry
`define FIFO_DEPTH        16
`define WORD_BITS         32
`define PORT_BITS         8

`endif

/* hdl/tx_input_sync.v */
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for a group of link pins
module tx_input_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1; // read only by stage two

  // first stage may go metastable; only sync_out is used downstream
  always @(posedge clk) begin
    if (reset) begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

`default_nettype wire

/* hdl/tx_word_fifo.v */
`timescale 1ns/1ps
`default_nettype none

// word fifo with a registered output stage
module tx_word_fifo #(
  parameter WIDTH = 46,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data,
  output reg  [AW:0]      level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage flops
  reg [AW-1:0]    wr_ptr;          // next slot to fill
  reg [AW-1:0]    rd_ptr;          // next slot to drain
  wire            push;
  wire            pop;

  assign in_ready = (level != DEPTH[AW:0]);
  assign push     = in_valid && in_ready;
  // load the output stage when it is empty or being drained
  assign pop      = (level != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  // storage write
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers, level and output stage
  always @(posedge clk) begin
    if (reset || flush) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      level     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr    <= rd_ptr + 1'b1;
        out_data  <= mem[rd_ptr];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* hdl/tx_framing_control.v */
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tx_framing_defines.vh"

// transmit framing and flow control of the system-side link
module tx_framing_control #(
  parameter PORTS = 8
) (
  input  wire                  clk,
  input  wire                  reset,
  // link pins, asynchronous to clk
  input  wire                  tx_system_clock,
  input  wire                  tx_transfer_enable_n,
  input  wire                  tx_first_word_marker,
  input  wire                  tx_last_word_marker,
  input  wire                  tx_inband_addr_strobe,
  input  wire [1:0]            tx_byte_modulus,
  input  wire                  tx_packet_error,
  input  wire [31:0]           tx_data,
  input  wire [7:0]            tx_port_addr,
  output reg                   tx_selected_space_avail_out,
  output reg                   tx_selected_space_avail_oe,
  // per-port fifo state from same-clock logic
  input  wire [PORTS-1:0]      port_above_almost_full,
  input  wire [PORTS-1:0]      port_full,
  // avalon-mm slave
  input  wire [3:0]            avs_address,
  input  wire                  avs_read,
  input  wire                  avs_write,
  input  wire [31:0]           avs_writedata,
  input  wire [3:0]            avs_byteenable,
  output reg  [31:0]           avs_readdata,
  output reg                   avs_waitrequest,
  // accepted words toward the port fifos
  output wire                  word_valid,
  input  wire                  word_ready,
  output wire [31:0]           word_data,
  output wire [7:0]            word_port,
  output wire                  word_first,
  output wire                  word_last,
  output wire                  word_abort,
  output wire [2:0]            word_bytes
);

  localparam SYNC_W = 48;          // clock + controls + data + address
  localparam FW     = 46;          // fifo entry width
  localparam AW     = 4;           // fifo address width

  // pin synchronisation
  // all pins share one two-flop path, so a word and its clock edge
  // reach the logic in the same cycle
  wire [SYNC_W-1:0] pins_async;    // raw pin group
  wire [SYNC_W-1:0] pins_sync;     // after two flops
  reg               link_clk_prev; // previous synced link clock

  assign pins_async = {tx_system_clock, tx_transfer_enable_n, tx_first_word_marker,
                       tx_last_word_marker, tx_inband_addr_strobe, tx_byte_modulus,
                       tx_packet_error, tx_data, tx_port_addr};

  tx_input_sync #(
    .WIDTH    (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  // data and clock share the same delay, so data are stable at the edge
  wire       s_clk   = pins_sync[47];
  wire       s_ten_n = pins_sync[46];
  wire       s_sox   = pins_sync[45];
  wire       s_eop   = pins_sync[44];
  wire       s_tsx   = pins_sync[43];
  wire [1:0] s_mod   = pins_sync[42:41];
  wire       s_err   = pins_sync[40];
  wire [31:0] s_data = pins_sync[39:8];
  wire [7:0] s_addr  = pins_sync[7:0];
  wire       link_edge;            // one cycle per rising link clock

  // edge finder on the synced link clock
  // prev resets low, the idle link clock level, so reset makes no edge
  always @(posedge clk) begin
    if (reset) begin
      link_clk_prev <= 1'b0;
    end else begin
      link_clk_prev <= s_clk;
    end
  end
  assign link_edge = s_clk && !link_clk_prev;

  // control registers
  reg [1:0]  bus_mode;             // cell/packet, level 2/3
  reg [1:0]  bus_width;            // 8, 16 or 32 bits
  reg        dp_reset;             // data path reset
  reg [15:0] abort_count;          // aborted packets
  reg [15:0] drop_count;           // words refused by a full fifo
  wire [AW:0] fifo_level;
  reg [7:0]  sel_port;             // port owning the current burst
  reg        port_selected;        // sel_port is a valid port
  reg        in_packet;            // between first and last word
  wire       req;
  wire       take;
  reg [31:0] read_mux;

  wire pkt_mode = (bus_mode == `MODE_L2_PKT) || (bus_mode == `MODE_L3_PKT);

  assign req  = avs_read || avs_write;
  // the request completes at the edge where waitrequest is low
  assign take = req && !avs_waitrequest;

  // read decode; unmapped offsets read zero
  // counters and status are read-only; writes to them are dropped
  always @* begin
    read_mux = 32'h0000_0000;
    case (avs_address)
      `REG_CTRL: begin
        read_mux[`CTRL_MODE_MSB:`CTRL_MODE_LSB]   = bus_mode;
        read_mux[`CTRL_WIDTH_MSB:`CTRL_WIDTH_LSB] = bus_width;
        read_mux[`CTRL_DP_RESET_BIT]              = dp_reset;
      end
      `REG_STATUS: begin
        read_mux[`STAT_PORT_MSB:`STAT_PORT_LSB]     = sel_port;
        read_mux[`STAT_SELECTED_BIT]                = port_selected;
        read_mux[`STAT_IN_PKT_BIT]                  = in_packet;
        read_mux[`STAT_LEVEL_LSB+AW:`STAT_LEVEL_LSB] = fifo_level;
      end
      `REG_ABORT_COUNT: begin
        read_mux[15:0] = abort_count;
      end
      `REG_DROP_COUNT: begin
        read_mux[15:0] = drop_count;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  // bus slave: one wait cycle, then the answer for exactly one cycle
  // read data are captured in the wait cycle and held until the next read
  always @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      bus_mode        <= `CTRL_RESET_MODE;
      bus_width       <= `CTRL_RESET_WIDTH;
      dp_reset        <= 1'b0;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= read_mux;
      end
      // only the control register is writable; low byte carries it
      if (take && avs_write && (avs_address == `REG_CTRL) && avs_byteenable[0]) begin
        bus_mode  <= avs_writedata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
        bus_width <= avs_writedata[`CTRL_WIDTH_MSB:`CTRL_WIDTH_LSB];
        dp_reset  <= avs_writedata[`CTRL_DP_RESET_BIT];
      end
    end
  end

  // transfer path
  // the link cannot be stalled inside a word, so a full fifo
  // costs the word and bumps the drop counter
  reg  [7:0] cand_port;            // address seen while enable is high
  wire       fifo_in_ready;
  wire       xfer;
  wire       strobe_ok;
  wire       is_last;
  wire       is_abort;
  reg  [2:0] bytes;
  wire [FW-1:0] fifo_in;
  wire [FW-1:0] fifo_out;

  // strobe counts only in level-3 packet mode with enable high
  assign strobe_ok = link_edge && s_tsx && s_ten_n && (bus_mode == `MODE_L3_PKT); // RULE11
  // a low enable moves one word on the sampled edge
  assign xfer      = link_edge && !s_ten_n && port_selected && !dp_reset; // RULE15 RULE1
  // the marker only matters in packet modes
  assign is_last   = pkt_mode && s_eop;                 // RULE8
  assign is_abort  = is_last && s_err;                  // RULE16

  // valid byte count of the word
  // cell modes never mark a last word, so their modulus is ignored
  always @* begin
    bytes = 3'h4;
    if (bus_width == `WIDTH_8) begin
      bytes = 3'h1;                                     // RULE14
    end else if (bus_width == `WIDTH_16) begin
      bytes = 3'h2;
      if (is_last && s_mod[0]) begin                    // RULE13 RULE14
        bytes = 3'h1;
      end
    end else if (is_last) begin
      case (s_mod)                                      // RULE12 RULE13
        2'h0: bytes = 3'h4;
        2'h1: bytes = 3'h3;
        2'h2: bytes = 3'h2;
        2'h3: bytes = 3'h1;
        default: bytes = 3'h4;
      endcase
    end
  end

  // entry layout: port, first, last, abort, bytes, data
  assign fifo_in = {sel_port, s_sox, is_last, is_abort, bytes, s_data};

  // port selection and packet tracking, one port per burst
  always @(posedge clk) begin
    if (reset) begin
      cand_port     <= 8'h00;
      sel_port      <= 8'h00;
      port_selected <= 1'b0;
      in_packet     <= 1'b0;
      abort_count   <= 16'h0000;
      drop_count    <= 16'h0000;
    end else if (dp_reset) begin
      // counters survive a data-path reset; only framing state drops
      port_selected <= 1'b0;
      in_packet     <= 1'b0;
    end else if (link_edge) begin
      if (bus_mode == `MODE_L3_PKT) begin
        if (strobe_ok) begin
          // address word only steers selection, never stored
          sel_port      <= s_data[7:0];           // RULE9 RULE10 RULE17
          port_selected <= (s_data[7:0] < PORTS);
        end
      end else if (s_ten_n) begin
        // address bus picks the port for the next burst
        cand_port     <= s_addr;                  // RULE18
        port_selected <= 1'b0;
      end else begin
        sel_port      <= cand_port;
        port_selected <= (cand_port < PORTS);
      end
      if (xfer) begin
        if (pkt_mode) begin
          if (s_sox) begin
            in_packet <= 1'b1;
          end
          if (is_last) begin
            in_packet <= 1'b0;
          end
        end
        if (is_abort) begin
          abort_count <= abort_count + 16'h0001;  // RULE16
        end
        // link cannot be stalled mid-word; a full fifo loses it
        if (!fifo_in_ready) begin
          drop_count <= drop_count + 16'h0001;
        end
      end
    end
  end

  // level-2 selection only takes effect on the first enable-low edge, so
  // the first level-2 word of each burst finds no port selected and is not taken
  tx_word_fifo #(
    .WIDTH     (FW),
    .DEPTH     (`FIFO_DEPTH),
    .AW        (AW)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .flush     (dp_reset),
    .in_valid  (xfer && !strobe_ok),               // RULE17
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (fifo_out),
    .level     (fifo_level)
  );

  // unpack the fifo head in the same layout
  assign word_port  = fifo_out[45:38];
  assign word_first = fifo_out[37];
  assign word_last  = fifo_out[36];
  assign word_abort = fifo_out[35];
  assign word_bytes = fifo_out[34:32];
  assign word_data  = fifo_out[31:0];

  // selected space available
  // space drops two words short of full to cover the pin lag
  wire port_room;                  // selected port above its threshold
  reg  next_space;
  reg  next_space_oe;

  // a full local fifo also counts as no room, so back-pressure reaches the link
  assign port_room = port_selected && (sel_port < PORTS) &&
                     port_above_almost_full[sel_port[AW-1:0] % PORTS] &&
                     !port_full[sel_port[AW-1:0] % PORTS] &&
                     (fifo_level < (`FIFO_DEPTH - 2));          // RULE2 RULE3

  // pin level and enable per mode
  // level-2 packet enable lags selection by one link edge
  always @* begin
    next_space    = 1'b0;
    next_space_oe = 1'b0;
    case (bus_mode)
      `MODE_L2_CELL: begin
        next_space_oe = 1'b0;                                   // RULE6
      end
      `MODE_L3_CELL: begin
        next_space_oe = 1'b1;                                   // RULE4 RULE6
        next_space    = 1'b0;
      end
      `MODE_L2_PKT: begin
        next_space_oe = port_selected && !s_ten_n && !dp_reset; // RULE5
        next_space    = port_room;
      end
      `MODE_L3_PKT: begin
        next_space_oe = 1'b1;                                   // RULE6
        next_space    = port_room && !dp_reset;
      end
      default: begin
        next_space_oe = 1'b0;
      end
    endcase
  end

  // pin updated on each link edge; global reset floats it
  // a register here keeps the pin free of glitches between edges
  always @(posedge clk) begin
    if (reset) begin
      tx_selected_space_avail_out <= 1'b0;                      // RULE7
      tx_selected_space_avail_oe  <= 1'b0;                      // RULE7
    end else if (link_edge) begin
      tx_selected_space_avail_out <= next_space;                // RULE18
      tx_selected_space_avail_oe  <= next_space_oe;
    end
  end

endmodule

`default_nettype wire

/* verif/tx_framing_props.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the space pin, the word stream and control writes
module tx_framing_props #(
  parameter PORTS = 8
) (
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             tx_selected_space_avail_out,
  input wire logic             tx_selected_space_avail_oe,
  input wire logic [PORTS-1:0] port_above_almost_full,
  input wire logic [3:0]       avs_address,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_writedata,
  input wire logic [3:0]       avs_byteenable,
  input wire logic             avs_waitrequest,
  input wire logic             word_valid,
  input wire logic             word_ready,
  input wire logic [31:0]      word_data,
  input wire logic             word_last,
  input wire logic             word_abort,
  input wire logic [2:0]       word_bytes
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [3:0] ctl;   // shadow of mode and width fields
  logic [5:0] quiet; // cycles since a control write, saturating
  // the pin moves only at link edges, so the level-3 mode checks wait for quiet
  always @(posedge clk) begin
    if (reset) begin
      ctl   <= 4'h0;
      quiet <= 6'h00;
    end else if (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0]) begin
      ctl   <= avs_writedata[3:0];
      quiet <= 6'h00;
    end else if (quiet != 6'h3f) begin
      quiet <= quiet + 6'h01;
    end
  end
  property p_reset_hiz;
    @(posedge clk) disable iff (1'b0) reset |=> !tx_selected_space_avail_oe;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("space pin driven in reset");
  property p_l2cell_hiz;
    ctl[1:0] == 2'h0 |-> !tx_selected_space_avail_oe;
  endproperty
  a_l2cell_hiz: assert property (p_l2cell_hiz) else $error("space pin driven in cell mode");
  property p_l3cell_low;
    ctl[1:0] == 2'h1 && quiet == 6'h3f |-> tx_selected_space_avail_oe && !tx_selected_space_avail_out;
  endproperty
  a_l3cell_low: assert property (p_l3cell_low) else $error("space pin not low");
  property p_l3pkt_drive;
    ctl[1:0] == 2'h3 && quiet == 6'h3f |-> tx_selected_space_avail_oe;
  endproperty
  a_l3pkt_drive: assert property (p_l3pkt_drive) else $error("space pin released");
  property p_rise_room;
    $rose(tx_selected_space_avail_out) |-> |$past(port_above_almost_full);
  endproperty
  a_rise_room: assert property (p_rise_room) else $error("space rose without room");
  property p_word_hold;
    word_valid && !word_ready |=> word_valid && $stable(word_data);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word lost before taken");
  property p_bytes_range;
    word_valid |-> word_bytes >= 3'h1 && word_bytes <= 3'h4;
  endproperty
  a_bytes_range: assert property (p_bytes_range) else $error("byte count out of range");
  property p_nonlast_full;
    word_valid && !word_last && ctl[1] && ctl[3:2] == 2'h2 |-> word_bytes == 3'h4;
  endproperty
  a_nonlast_full: assert property (p_nonlast_full) else $error("inner word not full");
  property p_narrow_one;
    word_valid && ctl[1] && ctl[3:2] == 2'h0 |-> word_bytes == 3'h1;
  endproperty
  a_narrow_one: assert property (p_narrow_one) else $error("byte bus word not one byte");
  property p_abort_last;
    word_valid && word_abort |-> word_last;
  endproperty
  a_abort_last: assert property (p_abort_last) else $error("abort off last word");
  c_abort: cover property (word_valid && word_abort);
  c_one_byte: cover property (word_valid && word_bytes == 3'h1);
  c_space: cover property ($rose(tx_selected_space_avail_out));
endmodule
bind tx_framing_control tx_framing_props #(.PORTS(PORTS)) props (.clk, .reset,
  .tx_selected_space_avail_out, .tx_selected_space_avail_oe, .port_above_almost_full,
  .avs_address, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
  .word_valid, .word_ready, .word_data, .word_last, .word_abort, .word_bytes);
`default_nettype wire

/* verif/link_model.sv */
`timescale 1ns/1ps
`default_nettype none
// link-layer source: one word per link clock, clock still between frames
module link_model (
  output logic        lclk,
  output logic        en_n,
  output logic        sox,
  output logic        eop,
  output logic        strb,
  output logic        err,
  output logic [1:0]  md,
  output logic [31:0] dat,
  output logic [7:0]  adr
);
  initial begin
    lclk = 1'b0;
    en_n = 1'b1;
    {sox, eop, strb, err, md, dat, adr} = '0;
  end
  // pins change after the falling edge, half a period of setup
  task cyc(input logic e, s, l, t, r, input logic [1:0] m, input logic [31:0] d,
           input logic [7:0] a);
    en_n = e;
    sox  = s;
    eop  = l;
    strb = t;
    err  = r;
    md   = m;
    dat  = d;
    adr  = a;
    #62.5 lclk = 1'b1;
    #62.5 lclk = 1'b0;
  endtask
  // idle: enable off, data no longer meaningful so it flips; clock still
  task rest;
    {en_n, sox, eop, strb, err} = 5'b10000;
    dat = ~dat;
    #125;
  endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] pafull = 8'h00; // ports above almost full
  logic [7:0] pfull = 8'h00;  // ports full
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic word_ready = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, word_valid, word_first, word_last, word_abort, sp_out, sp_oe;
  wire [31:0] word_data;
  wire [7:0] word_port;
  wire [2:0] word_bytes;
  wire lclk, en_n, sox, eop, strb, err;
  wire [1:0] md;
  wire [31:0] dat;
  wire [7:0] adr;
  int errors = 0;
  int cmp_count = 0;
  logic [45:0] w;  // popped word: port, data, first, last, abort, bytes
  logic [31:0] q;  // last read data
  always #2 clk = ~clk;
  link_model lm (.lclk(lclk), .en_n(en_n), .sox(sox), .eop(eop), .strb(strb),
    .err(err), .md(md), .dat(dat), .adr(adr));
  tx_framing_control dut (.clk, .reset, .tx_system_clock(lclk),
    .tx_transfer_enable_n(en_n), .tx_first_word_marker(sox), .tx_last_word_marker(eop),
    .tx_inband_addr_strobe(strb), .tx_byte_modulus(md), .tx_packet_error(err),
    .tx_data(dat), .tx_port_addr(adr), .tx_selected_space_avail_out(sp_out),
    .tx_selected_space_avail_oe(sp_oe), .port_above_almost_full(pafull),
    .port_full(pfull), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .word_valid, .word_ready,
    .word_data, .word_port, .word_first, .word_last, .word_abort, .word_bytes);
  task report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task expect1(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task timeout;
    errors++;
    $display("CHECK FAILED %0t wait ran out", $time);
    report_and_stop;
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) timeout;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // take one word off the fifo output
  task pop;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (word_valid !== 1'b1 && n < 300);
    if (word_valid !== 1'b1) timeout;
    w = {word_port, word_data, word_first, word_last, word_abort, word_bytes};
    word_ready <= 1'b1;
    @(posedge clk);
    word_ready <= 1'b0;
  endtask
  task wd(input logic s, l, r, input logic [1:0] m, input logic [31:0] d);
    lm.cyc(1'b0, s, l, 1'b0, r, m, d, 8'h00);
  endtask
  task sel(input logic [7:0] p);
    lm.cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, {24'h0, p}, 8'h00);
  endtask
  task t_regs;
    bus(1'b0, 4'h0, 32'h0);
    expect1(q === 32'h0, "control reset value");
    bus(1'b1, 4'hc, 32'hffff);
    bus(1'b0, 4'hc, 32'h0);
    expect1(q === 32'h0, "read-only count written");
    bus(1'b0, 4'h2, 32'h0);
    expect1(q === 32'h0, "unmapped read");
    lm.cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 32'h0, 8'h01);
    expect1(sp_oe === 1'b0, "space driven in cell mode");
    $display("test regs done");
  endtask
  task t_l3pkt;
    bus(1'b1, 4'h0, 32'h0b);
    @(posedge clk) pafull <= 8'h20;
    sel(8'h05);
    wd(1'b1, 1'b0, 1'b0, 2'h3, 32'h11223344);
    wd(1'b0, 1'b1, 1'b0, 2'h1, 32'h55667788);
    lm.rest;
    pop;
    expect1(w === {8'h05, 32'h11223344, 3'h4, 3'h4}, "first word");
    pop;
    expect1(w === {8'h05, 32'h55667788, 3'h2, 3'h3}, "last word");
    expect1(sp_out === 1'b1 && sp_oe === 1'b1, "space not high");
    @(posedge clk) pfull <= 8'h20;
    lm.cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 32'h0, 8'h00);
    expect1(sp_out === 1'b0, "space high on full port");
    @(posedge clk) pfull <= 8'h00;
    $display("test l3pkt done");
  endtask
  task t_mod;
    int i;
    for (i = 0; i < 4; i++) begin
      wd(1'b1, 1'b1, 1'b0, i[1:0], i);
      pop;
      expect1(w[2:0] === 3'h4 - i[2:0], "modulus bytes");
    end
    wd(1'b1, 1'b1, 1'b1, 2'h0, 32'h0);
    pop;
    expect1(w[4:3] === 2'h3, "abort not flagged");
    bus(1'b0, 4'h8, 32'h0);
    expect1(q[15:0] === 16'h0001, "abort count");
    lm.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0, 32'h07, 8'h00);
    pop;
    expect1(w[45:6] === {8'h05, 32'h07}, "strobe taken while enabled");
    bus(1'b1, 4'h0, 32'h07);
    sel(8'h05);
    for (i = 2; i < 4; i++) begin
      wd(1'b1, 1'b1, 1'b0, i[1:0], i);
      pop;
      expect1(w[2:0] === 3'h2 - i[0], "half bus bytes");
    end
    bus(1'b1, 4'h0, 32'h03);
    sel(8'h05);
    wd(1'b1, 1'b1, 1'b0, 2'h3, 32'h0);
    pop;
    expect1(w[2:0] === 3'h1, "byte bus bytes");
    lm.rest;
    $display("test mod done");
  endtask
  // fill past the fifo with the drain stalled, then drain it dry
  task t_fill;
    int i, n;
    n = 0;
    for (i = 0; i < 20; i++) wd(1'b0, 1'b0, 1'b0, 2'h0, i);
    lm.rest;
    expect1(sp_out === 1'b0, "space high with fifo full");
    bus(1'b0, 4'hc, 32'h0);
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (word_valid === 1'b1) begin
        pop;
        n++;
      end
    end
    expect1(q[15:0] != 16'h0 && q[15:0] + n[15:0] === 16'h0014, "drop count");
    $display("test fill done");
  endtask
  task t_modes;
    bus(1'b1, 4'h0, 32'h01);
    @(posedge clk) pafull <= 8'hff;
    lm.cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 32'h0, 8'h05);
    expect1(sp_oe === 1'b1 && sp_out === 1'b0, "cell level-3 space");
    bus(1'b1, 4'h0, 32'h02);
    lm.cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 32'h0, 8'h05);
    lm.cyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 32'h0, 8'h05);
    lm.cyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 32'h0, 8'h05);
    expect1(sp_oe === 1'b1 && sp_out === 1'b1, "space released while selected");
    lm.cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 32'h0, 8'h05);
    expect1(sp_oe === 1'b0, "space driven with enable off");
    bus(1'b1, 4'h0, 32'h01);
    lm.cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 32'h0, 8'h05);
    repeat (40) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    expect1(sp_oe === 1'b0 && word_valid === 1'b0, "outputs live in reset");
    reset <= 1'b0;
    $display("test modes done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    expect1(sp_oe === 1'b0 && avs_waitrequest === 1'b1, "reset outputs");
    reset <= 1'b0;
    t_regs;
    t_l3pkt;
    t_mod;
    t_fill;
    t_modes;
    report_and_stop;
  end
endmodule
`default_nettype wire
